/* File: core/bit_sync.sv */
// two-flop synchroniser for a vector of unrelated levels
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce_in) begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;
endmodule : bit_sync
`default_nettype wire

/* File: core/reg_image.sv */
// snapshot memory: written on the core clock, read on the link clock
`timescale 1ns/1ps
`default_nettype none
module reg_image #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic wclk_in,
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  input wire logic rclk_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [WIDTH-1:0] rdata_out
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge wclk_in) begin
    if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  // only read while writes are held off, so the word is stable
  always_ff @(posedge rclk_in) begin
    rdata_out <= mem_q[raddr_in];
  end
endmodule : reg_image
`default_nettype wire

/* File: core/supply_i2c_regs.sv */
// two-wire register bank of a dual antenna-supply controller
//
// How it works
// - answer address 0001 00xx, lsb is direction
// - all registers clear at power-on
// - direction 0 writes the byte-selected register
// - byte bits 7..5 select register, 000..011 channel one
// - select bits read back, flags read-only
// - overload and back-current flags reflect limiting
// - voltage-range flag reflects out-of-range supply
// - cable flag 1 open, 0 connected
// - over-temperature flag set, power blocks disabled
// - 00 gives internal tone gated by modulation pin
// - 01 passes external modulated signal through
// - 10 gives continuous internal tone
// - threshold bit picks receive or transmit level
// - limit-mode bit 1 static, 0 dynamic
// - range and high/low bits pick limit threshold
// - pin-override bit 0 enables select pin
// - override 1: high/low bits pick voltage
// - override 0: pin picks range, bit picks level
// - channel-enable bit switches only its own channel's regulator
// - unused and status bits ignored on write
// - read sends bytes msb first until no-ack
// - power-good low ignores bus, clears registers
`timescale 1ns/1ps
`default_nettype none
module supply_i2c_regs (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic scl_clk_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic power_good_in,
  input wire logic over_temp_in,
  input wire logic [1:0] cable_open_in,
  input wire logic [1:0] voltage_range_in,
  input wire logic [1:0] overload_in,
  input wire logic [1:0] back_current_in,
  input wire logic [1:0] voltage_select_pin_in,
  input wire logic [1:0] modulation_input_pin_in,
  output logic [1:0] power_enable_out,
  output logic [3:0] volt_sel_out,
  output logic [1:0] limit_static_out,
  output logic [5:0] limit_code_out,
  output logic [1:0] tone_out,
  output logic [1:0] tone_thresh_out
);

  // ---------------------------------------------------------------
  // synchronisers into the core domain
  // ---------------------------------------------------------------
  logic wr_tog_q;
  logic [16:0] async_vec;
  logic [16:0] sync_vec;
  logic sda_s;
  logic scl_s;
  logic pg_s;
  logic ot_s;
  logic tog_s;
  logic [1:0] cab_s;
  logic [1:0] ouv_s;
  logic [1:0] ol_s;
  logic [1:0] bc_s;
  logic [1:0] vsp_s;
  logic [1:0] mod_s;

  assign async_vec = {sda_in, scl_clk_in, power_good_in, over_temp_in,
                      cable_open_in, voltage_range_in, overload_in,
                      back_current_in, voltage_select_pin_in,
                      modulation_input_pin_in, wr_tog_q};

  bit_sync #(
    .WIDTH(17)
  ) u_sync (
    .clk_in(core_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .d_in(async_vec),
    .q_out(sync_vec)
  );

  assign {sda_s, scl_s, pg_s, ot_s, cab_s, ouv_s, ol_s, bc_s, vsp_s, mod_s,
          tog_s} = sync_vec;

  // ---------------------------------------------------------------
  // bus start / stop watch and link engine hold
  // ---------------------------------------------------------------
  logic sda_prev_q;
  logic idle_q;
  logic stop_pend_q;
  logic tog_prev_q;
  logic start_seen;
  logic stop_seen;
  logic wr_pend;
  logic wr_evt;

  assign start_seen = scl_s & sda_prev_q & ~sda_s;
  assign stop_seen = scl_s & ~sda_prev_q & sda_s;
  assign wr_pend = tog_s ^ tog_prev_q;
  assign wr_evt = wr_pend & ~idle_q & pg_s;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sda_prev_q <= 1'b1;
    end else if (ce_in) begin
      sda_prev_q <= sda_s;
    end
  end

  // idle holds the link engine in reset between frames
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      idle_q <= 1'b1;
      stop_pend_q <= 1'b0;
    end else if (ce_in) begin
      if (!pg_s) begin
        idle_q <= 1'b1;
        stop_pend_q <= 1'b0;
      end else if (start_seen) begin
        idle_q <= 1'b0;
        stop_pend_q <= 1'b0;
      end else if (stop_seen || stop_pend_q) begin
        // last byte must land before the engine is reset
        if (wr_pend) begin
          stop_pend_q <= 1'b1;
        end else begin
          idle_q <= 1'b1;
          stop_pend_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      tog_prev_q <= 1'b0;
    end else if (ce_in) begin
      if (idle_q || wr_evt) begin
        tog_prev_q <= tog_s;
      end
    end
  end

  // ---------------------------------------------------------------
  // system registers
  // ---------------------------------------------------------------
  logic [4:0] ctrl_q [supply_regs_pkg::NUM_REGS];
  logic [7:0] wr_byte_q;

  function automatic logic [4:0] wr_mask(input logic [2:0] sel);
    case (sel[1:0])
      supply_regs_pkg::SEL_STATUS: wr_mask = supply_regs_pkg::MASK_STATUS;
      supply_regs_pkg::SEL_TONE: wr_mask = supply_regs_pkg::MASK_TONE;
      supply_regs_pkg::SEL_CURRENT: wr_mask = supply_regs_pkg::MASK_CURRENT;
      supply_regs_pkg::SEL_OUTPUT: wr_mask = supply_regs_pkg::MASK_OUTPUT;
      default: wr_mask = supply_regs_pkg::MASK_STATUS;
    endcase
  endfunction : wr_mask

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < supply_regs_pkg::NUM_REGS; i++) begin
        ctrl_q[i] <= supply_regs_pkg::REG_RESET;
      end
    end else if (ce_in) begin
      if (!pg_s) begin
        for (int i = 0; i < supply_regs_pkg::NUM_REGS; i++) begin
          ctrl_q[i] <= supply_regs_pkg::REG_RESET;
        end
      end else if (wr_evt) begin
        // byte is stable in the link domain until the next byte ends
        ctrl_q[wr_byte_q[7:5]] <= wr_byte_q[4:0] & wr_mask(wr_byte_q[7:5]);
      end
    end
  end

  // ---------------------------------------------------------------
  // read image, refreshed only while the link engine is idle
  // ---------------------------------------------------------------
  logic [2:0] img_idx_q;
  logic [7:0] img_wdata;
  logic [4:0] stat_lo;
  logic [2:0] rd_addr;
  logic [7:0] rd_data;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      img_idx_q <= 3'h0;
    end else if (ce_in) begin
      img_idx_q <= img_idx_q + 3'h1;
    end
  end

  always_comb begin
    stat_lo = supply_regs_pkg::REG_RESET;
    if (!img_idx_q[2]) begin
      stat_lo[supply_regs_pkg::OVER_TEMP_POS] = ot_s;
    end
    stat_lo[3:0] = {cab_s[img_idx_q[2]], ouv_s[img_idx_q[2]],
                    ol_s[img_idx_q[2]], bc_s[img_idx_q[2]]};
    if (img_idx_q[1:0] == supply_regs_pkg::SEL_STATUS) begin
      img_wdata = {img_idx_q, stat_lo};
    end else begin
      img_wdata = {img_idx_q, ctrl_q[img_idx_q]};
    end
  end

  reg_image #(
    .WIDTH(8),
    .DEPTH(supply_regs_pkg::NUM_REGS),
    .AW(3)
  ) u_image (
    .wclk_in(core_clk_in),
    .we_in(idle_q & ce_in),
    .waddr_in(img_idx_q),
    .wdata_in(img_wdata),
    .rclk_in(scl_clk_in),
    .raddr_in(rd_addr),
    .rdata_out(rd_data)
  );

  // ---------------------------------------------------------------
  // link engine on the bus clock
  // ---------------------------------------------------------------
  supply_regs_pkg::link_state_t st_q;
  logic [2:0] cnt_q;
  logic [6:0] shift_q;
  logic rw_q;
  logic [2:0] rd_idx_q;
  logic sda_oe_q;
  logic last_bit;

  assign last_bit = (cnt_q == 3'h7);

  always_ff @(posedge scl_clk_in or posedge idle_q) begin
    if (idle_q) begin
      st_q <= supply_regs_pkg::ST_ADDR;
      cnt_q <= 3'h0;
      rw_q <= 1'b0;
    end else begin
      case (st_q)
        supply_regs_pkg::ST_ADDR: begin
          cnt_q <= cnt_q + 3'h1;
          if (last_bit) begin
            rw_q <= sda_in;
            if (shift_q[6:1] == supply_regs_pkg::ADDR_PAT) begin
              st_q <= supply_regs_pkg::ST_AACK;
            end else begin
              st_q <= supply_regs_pkg::ST_IGNORE;
            end
          end
        end
        supply_regs_pkg::ST_AACK: begin
          st_q <= rw_q ? supply_regs_pkg::ST_RDATA : supply_regs_pkg::ST_WDATA;
        end
        supply_regs_pkg::ST_WDATA: begin
          cnt_q <= cnt_q + 3'h1;
          if (last_bit) begin
            st_q <= supply_regs_pkg::ST_WACK;
          end
        end
        supply_regs_pkg::ST_WACK: begin
          st_q <= supply_regs_pkg::ST_WDATA;
        end
        supply_regs_pkg::ST_RDATA: begin
          cnt_q <= cnt_q + 3'h1;
          if (last_bit) begin
            st_q <= supply_regs_pkg::ST_RACK;
          end
        end
        supply_regs_pkg::ST_RACK: begin
          // host no-ack ends the read
          st_q <= sda_in ? supply_regs_pkg::ST_IGNORE : supply_regs_pkg::ST_RDATA;
        end
        supply_regs_pkg::ST_IGNORE: begin
          st_q <= supply_regs_pkg::ST_IGNORE;
        end
        default: begin
          st_q <= supply_regs_pkg::ST_IGNORE;
        end
      endcase
    end
  end

  always_ff @(posedge scl_clk_in or posedge idle_q) begin
    if (idle_q) begin
      shift_q <= 7'h00;
    end else begin
      shift_q <= {shift_q[5:0], sda_in};
    end
  end

  // completed write byte and its toggle toward the core
  always_ff @(posedge scl_clk_in or posedge idle_q) begin
    if (idle_q) begin
      wr_byte_q <= supply_regs_pkg::BYTE_RESET;
      wr_tog_q <= 1'b0;
    end else if (st_q == supply_regs_pkg::ST_WDATA && last_bit) begin
      wr_byte_q <= {shift_q, sda_in};
      wr_tog_q <= ~wr_tog_q;
    end
  end

  // read index walks the registers from the first one per frame
  always_ff @(posedge scl_clk_in or posedge idle_q) begin
    if (idle_q) begin
      rd_idx_q <= 3'h0;
    end else if (st_q == supply_regs_pkg::ST_RDATA && last_bit) begin
      rd_idx_q <= rd_idx_q + 3'h1;
    end
  end

  assign rd_addr = (st_q == supply_regs_pkg::ST_RDATA && last_bit) ?
                   rd_idx_q + 3'h1 : rd_idx_q;

  // pin driven on the falling edge so it is settled while clock is high
  always_ff @(negedge scl_clk_in or posedge idle_q) begin
    if (idle_q) begin
      sda_oe_q <= 1'b0;
    end else begin
      sda_oe_q <= (st_q == supply_regs_pkg::ST_AACK) ||
                  (st_q == supply_regs_pkg::ST_WACK) ||
                  (st_q == supply_regs_pkg::ST_RDATA && !rd_data[~cnt_q]);
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = sda_oe_q;

  // ---------------------------------------------------------------
  // internal tone oscillator
  // ---------------------------------------------------------------
  logic [supply_regs_pkg::TONE_CNT_W-1:0] tone_cnt_q;
  logic tone_osc_q;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      tone_cnt_q <= '0;
      tone_osc_q <= 1'b0;
    end else if (ce_in) begin
      if (tone_cnt_q ==
          supply_regs_pkg::TONE_CNT_W'(supply_regs_pkg::TONE_HALF_CYC - 1)) begin
        tone_cnt_q <= '0;
        tone_osc_q <= ~tone_osc_q;
      end else begin
        tone_cnt_q <= tone_cnt_q + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // per-channel control outputs
  // ---------------------------------------------------------------
  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic [4:0] tone_b;
    logic [4:0] cur_b;
    logic [4:0] out_b;
    logic pwr_q;
    logic tone_q;
    logic thresh_q;
    logic static_q;
    logic [1:0] volt_q;
    logic [2:0] limit_q;

    assign tone_b = ctrl_q[c*4+1];
    assign cur_b = ctrl_q[c*4+2];
    assign out_b = ctrl_q[c*4+3];

    always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
        pwr_q <= 1'b0;
        tone_q <= 1'b0;
        thresh_q <= 1'b0;
      end else if (ce_in) begin
        pwr_q <= out_b[supply_regs_pkg::CHAN_ENABLE_POS] & ~ot_s;
        thresh_q <= tone_b[supply_regs_pkg::TONE_THRESH_POS];
        case ({tone_b[supply_regs_pkg::TONE_ENABLE_POS],
               tone_b[supply_regs_pkg::TONE_SOURCE_POS]})
          2'b00: tone_q <= tone_osc_q & mod_s[c];
          2'b01: tone_q <= mod_s[c];
          2'b10: tone_q <= tone_osc_q;
          default: tone_q <= 1'b0;
        endcase
      end
    end

    always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
        static_q <= 1'b0;
        volt_q <= 2'h0;
        limit_q <= 3'h0;
      end else if (ce_in) begin
        static_q <= cur_b[supply_regs_pkg::LIMIT_MODE_POS];
        if (cur_b[supply_regs_pkg::LIMIT_RANGE_POS]) begin
          limit_q <= {1'b0, cur_b[supply_regs_pkg::LIMIT_HIGH_POS],
                      cur_b[supply_regs_pkg::LIMIT_LOW_POS]} + 3'h1;
        end else begin
          limit_q <= 3'h0;
        end
        if (cur_b[supply_regs_pkg::PIN_OVERRIDE_POS]) begin
          volt_q <= {out_b[supply_regs_pkg::HIGH_RANGE_POS],
                     out_b[supply_regs_pkg::LOW_RANGE_POS]};
        end else if (vsp_s[c]) begin
          volt_q <= {1'b1, out_b[supply_regs_pkg::HIGH_RANGE_POS]};
        end else begin
          volt_q <= {1'b0, out_b[supply_regs_pkg::LOW_RANGE_POS]};
        end
      end
    end

    assign power_enable_out[c] = pwr_q;
    assign tone_out[c] = tone_q;
    assign tone_thresh_out[c] = thresh_q;
    assign limit_static_out[c] = static_q;
    assign volt_sel_out[c*2+1:c*2] = volt_q;
    assign limit_code_out[c*3+2:c*3] = limit_q;
  end

endmodule : supply_i2c_regs
`default_nettype wire

/* File: core/supply_regs_pkg.sv */
// constants and types shared by the supply register bank
package supply_regs_pkg;

  // ---------------------------------------------------------------
  // clocking and tone
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int TONE_HZ = 22_000;
  localparam int TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);
  localparam int TONE_CNT_W = 10;

  // ---------------------------------------------------------------
  // link address and register map
  // ---------------------------------------------------------------
  localparam logic [5:0] ADDR_PAT = 6'h04;
  localparam int NUM_REGS = 8;
  localparam logic [1:0] SEL_STATUS = 2'h0;
  localparam logic [1:0] SEL_TONE = 2'h1;
  localparam logic [1:0] SEL_CURRENT = 2'h2;
  localparam logic [1:0] SEL_OUTPUT = 2'h3;
  localparam logic [4:0] REG_RESET = 5'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ---------------------------------------------------------------
  // writable low-field masks
  // ---------------------------------------------------------------
  localparam logic [4:0] MASK_STATUS = 5'h00;
  localparam logic [4:0] MASK_TONE = 5'h1C;
  localparam logic [4:0] MASK_CURRENT = 5'h1F;
  localparam logic [4:0] MASK_OUTPUT = 5'h13;

  // ---------------------------------------------------------------
  // field positions within the low five bits
  // ---------------------------------------------------------------
  localparam int OVER_TEMP_POS = 4;
  localparam int TONE_ENABLE_POS = 4;
  localparam int TONE_SOURCE_POS = 3;
  localparam int TONE_THRESH_POS = 2;
  localparam int LIMIT_MODE_POS = 4;
  localparam int PIN_OVERRIDE_POS = 3;
  localparam int LIMIT_RANGE_POS = 2;
  localparam int LIMIT_HIGH_POS = 1;
  localparam int LIMIT_LOW_POS = 0;
  localparam int CHAN_ENABLE_POS = 4;
  localparam int HIGH_RANGE_POS = 1;
  localparam int LOW_RANGE_POS = 0;

  // ---------------------------------------------------------------
  // link engine states
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_ADDR = 7'h01,
    ST_AACK = 7'h02,
    ST_WDATA = 7'h04,
    ST_WACK = 7'h08,
    ST_RDATA = 7'h10,
    ST_RACK = 7'h20,
    ST_IGNORE = 7'h40
  } link_state_t;

endpackage : supply_regs_pkg

/* File: sim/dual_lnb_i2c_system_registers_tb.sv */
// self-checking bench for the supply register bank
`timescale 1ns/1ps
`default_nettype none
module dual_lnb_i2c_system_registers_tb;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic power_good_in = 1'b1;
  logic over_temp_in = 1'b0;
  logic [1:0] cable_open_in = 2'h0, voltage_range_in = 2'h0, overload_in = 2'h0;
  logic [1:0] back_current_in = 2'h0, voltage_select_pin_in = 2'h0, modulation_input_pin_in = 2'h0;
  logic scl, sda_pull, sda_oe, sda_o;
  logic [1:0] power_enable_out, limit_static_out, tone_out, tone_thresh_out;
  logic [3:0] volt_sel_out;
  logic [5:0] limit_code_out;
  wire logic sda_line;
  logic [4:0] shadow [8];
  logic [4:0] wm [4] = '{5'h00, 5'h1C, 5'h1F, 5'h13};
  logic [7:0] bad [3] = '{8'h00, 8'h14, 8'h91};
  logic [7:0] q [$];
  int seed = 80002;
  int miscompares = 0;
  int num_checks = 0;
  // open-drain wire: low while either side pulls it to the device's driven level
  assign sda_line = !(sda_pull | (sda_oe & !sda_o));
  always #25 core_clk_in = !core_clk_in;
  i2c_host_model host (.scl_out(scl), .sda_pull_out(sda_pull), .sda_in(sda_line));
  supply_i2c_regs uut (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(1'b1),
    .scl_clk_in(scl), .sda_in(sda_line), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .power_good_in(power_good_in), .over_temp_in(over_temp_in), .cable_open_in(cable_open_in),
    .voltage_range_in(voltage_range_in), .overload_in(overload_in),
    .back_current_in(back_current_in), .voltage_select_pin_in(voltage_select_pin_in),
    .modulation_input_pin_in(modulation_input_pin_in), .power_enable_out(power_enable_out),
    .volt_sel_out(volt_sel_out), .limit_static_out(limit_static_out),
    .limit_code_out(limit_code_out), .tone_out(tone_out), .tone_thresh_out(tone_thresh_out));
  // ---------------------------------------------------------------
  // checking and expectation helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  function automatic logic [7:0] rd_exp(input logic [2:0] i);
    logic c;
    c = i[2];
    if (i[1:0] != 2'h0)
      return {i, shadow[i]};
    return {i, over_temp_in & !c, cable_open_in[c], voltage_range_in[c], overload_in[c],
      back_current_in[c]};
  endfunction : rd_exp
  task automatic wr_frame(input logic [7:0] a, input logic [7:0] d [$], input logic ok);
    logic ack;
    @(negedge core_clk_in);
    host.start();
    host.wr_byte(a, ack);
    check({7'h0, ack}, {7'h0, ok});
    if (ok)
      foreach (d[k]) begin
        host.wr_byte(d[k], ack);
        check({7'h0, ack}, 8'h1);
        shadow[d[k][7:5]] = d[k][4:0] & wm[d[k][6:5]];
      end
    host.stop();
  endtask : wr_frame
  task automatic rd_all(input logic [7:0] a);
    logic ack;
    logic [7:0] d;
    @(negedge core_clk_in);
    host.start();
    host.wr_byte(a, ack);
    check({7'h0, ack}, 8'h1);
    for (int k = 0; k < 8; k++) begin
      host.rd_byte(k == 7, d);
      check(d, rd_exp(3'(k)));
    end
    host.stop();
  endtask : rd_all
  task automatic chk_outputs();
    logic [4:0] cr, ou;
    logic [1:0] v;
    for (int c = 0; c < 2; c++) begin
      cr = shadow[c * 4 + 2];
      ou = shadow[c * 4 + 3];
      v = cr[3] ? ou[1:0] : {voltage_select_pin_in[c], voltage_select_pin_in[c] ? ou[1] : ou[0]};
      check({6'h0, volt_sel_out[c * 2 +: 2]}, {6'h0, v});
      check({7'h0, power_enable_out[c]}, {7'h0, ou[4] & !over_temp_in});
      check({7'h0, limit_static_out[c]}, {7'h0, cr[4]});
      check({5'h0, limit_code_out[c * 3 +: 3]}, cr[2] ? 8'(cr[1:0]) + 8'h1 : 8'h0);
      check({7'h0, tone_thresh_out[c]}, {7'h0, shadow[c * 4 + 1][2]});
    end
  endtask : chk_outputs
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    #3_000_000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    logic [1:0] last, moved, m;
    logic p, tog;
    foreach (shadow[i]) shadow[i] = 5'h00;
    repeat (8) @(negedge core_clk_in);
    rst_in = 1'b0;
    repeat (15) @(negedge core_clk_in);
    rd_all(8'h11);
    chk_outputs();
    $display("test reset finished");
    wr_frame(8'h12, '{8'h1F, 8'h9F, 8'h7F, 8'hFF, 8'h3F, 8'h5F}, 1'b1);
    rd_all(8'h13);
    $display("test fields finished");
    foreach (bad[i]) wr_frame(bad[i], '{8'h60}, 1'b0);
    rd_all(8'h11);
    $display("test address finished");
    for (int n = 0; n < 12; n++) begin
      @(negedge core_clk_in);
      {over_temp_in, cable_open_in, voltage_range_in, overload_in, back_current_in,
        voltage_select_pin_in, modulation_input_pin_in} = 13'($random(seed));
      q.delete();
      repeat (1 + n % 3) q.push_back(8'($random(seed)));
      wr_frame(n[0] ? 8'h12 : 8'h10, q, 1'b1);
      repeat (10) @(negedge core_clk_in);
      chk_outputs();
      rd_all(8'h11);
    end
    $display("test random finished");
    @(negedge core_clk_in);
    {power_good_in, modulation_input_pin_in} = 3'h0;
    foreach (shadow[i]) shadow[i] = 5'h00;
    repeat (10) @(negedge core_clk_in);
    wr_frame(8'h10, '{8'h7F}, 1'b0);
    chk_outputs();
    @(negedge core_clk_in);
    power_good_in = 1'b1;
    repeat (15) @(negedge core_clk_in);
    rd_all(8'h11);
    $display("test power finished");
    for (int k = 0; k < 8; k++) begin
      m = 2'(k >> 1);
      p = k[0];
      @(negedge core_clk_in);
      modulation_input_pin_in = {p, p};
      wr_frame(8'h10, '{{3'h1, m, 3'h0}, {3'h5, m, 3'h0}}, 1'b1);
      repeat (20) @(negedge core_clk_in);
      moved = 2'h0;
      last = tone_out;
      repeat (1000) begin
        @(negedge core_clk_in);
        moved |= tone_out ^ last;
        last = tone_out;
      end
      tog = m == 2'h2 || (m == 2'h0 && p);
      check({6'h0, moved}, {6'h0, {2{tog}}});
      if (!tog)
        check({6'h0, tone_out}, {6'h0, {2{m == 2'h1 && p}}});
    end
    $display("test tone finished");
    report_and_stop();
  end
endmodule : dual_lnb_i2c_system_registers_tb
`default_nettype wire

/* File: sim/i2c_host_model.sv */
// bus master model driving the two-wire register link
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  output logic scl_out,
  output logic sda_pull_out,
  input wire logic sda_in
);
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  // ---------------------------------------------------------------
  // framing, clock stands high between frames
  // ---------------------------------------------------------------
  task automatic start();
    #7 sda_pull_out = 1'b1;
    #200 scl_out = 1'b0;
  endtask : start
  task automatic stop();
    #20 sda_pull_out = 1'b1;
    #60 scl_out = 1'b1;
    #80 sda_pull_out = 1'b0;
    #700;
  endtask : stop
  // data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    #20 sda_pull_out = !b;
    #60 scl_out = 1'b1;
    #40 r = sda_in;
    #40 scl_out = 1'b0;
  endtask : bit_io
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wr_byte
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask : rd_byte
endmodule : i2c_host_model
`default_nettype wire

/* File: sim/supply_regs_sva.sv */
// assertion checker for the supply register bank
`timescale 1ns/1ps
`default_nettype none
module supply_regs_sva (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic scl_clk_in,
  input wire logic sda_oe_out,
  input wire logic power_good_in,
  input wire logic over_temp_in,
  input wire logic [1:0] voltage_select_pin_in,
  input wire logic [1:0] modulation_input_pin_in,
  input wire logic [1:0] power_enable_out,
  input wire logic [3:0] volt_sel_out,
  input wire logic [1:0] limit_static_out,
  input wire logic [5:0] limit_code_out,
  input wire logic [1:0] tone_out,
  input wire logic [1:0] tone_thresh_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // ---------------------------------------------------------------
  // link and register relations
  // ---------------------------------------------------------------
  oe_scl_low_a: assert property ($changed(sda_oe_out) |-> !scl_clk_in)
    else $error("data drive moved while bus clock high");
  idle_release_a: assert property (scl_clk_in [*6] |-> !sda_oe_out)
    else $error("data line held low on idle bus");
  reset_zero_a: assert property (disable iff (1'b0) rst_in [*2] |->
    power_enable_out == 2'h0 && volt_sel_out == 4'h0 && limit_code_out == 6'h0 && !sda_oe_out)
    else $error("outputs not cleared in reset");
  over_temp_a: assert property (over_temp_in [*4] |-> power_enable_out == 2'h0)
    else $error("power on during over-temperature");
  pg_clear_a: assert property (!power_good_in [*8] |-> power_enable_out == 2'h0 &&
    limit_code_out == 6'h0 && limit_static_out == 2'h0 && tone_thresh_out == 2'h0 && !sda_oe_out)
    else $error("registers not cleared while power low");
  pg_volt_a: assert property ((!power_good_in && $stable(voltage_select_pin_in)) [*8] |->
    volt_sel_out == {voltage_select_pin_in[1], 1'b0, voltage_select_pin_in[0], 1'b0})
    else $error("voltage select not following pin");
  pg_tone_a: assert property ((!power_good_in && modulation_input_pin_in == 2'h0) [*8] |->
    tone_out == 2'h0)
    else $error("tone present with gate low");
  cfg_stable_a: assert property ((scl_clk_in && power_good_in) [*8] |->
    $stable(limit_code_out) && $stable(limit_static_out) && $stable(tone_thresh_out))
    else $error("settings changed on idle bus");
  cover property ($rose(sda_oe_out));
  cover property (power_enable_out == 2'h3);
  cover property ($fell(power_good_in));
endmodule : supply_regs_sva
bind supply_i2c_regs supply_regs_sva chk (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .scl_clk_in(scl_clk_in), .sda_oe_out(sda_oe_out), .power_good_in(power_good_in),
  .over_temp_in(over_temp_in), .voltage_select_pin_in(voltage_select_pin_in),
  .modulation_input_pin_in(modulation_input_pin_in), .power_enable_out(power_enable_out),
  .volt_sel_out(volt_sel_out), .limit_static_out(limit_static_out),
  .limit_code_out(limit_code_out), .tone_out(tone_out), .tone_thresh_out(tone_thresh_out));
`default_nettype wire
